// >>> design/sop_programmer.sv
`timescale 1ns/10ps
module sop_programmer #(
    parameter logic [sop_pkg::IDLE_W-1:0] IDLE_TIMEOUT_OSC =
        sop_pkg::IDLE_W'(sop_pkg::IDLE_TIMEOUT_OSC),
    parameter int                         BUF_DEPTH        = 2
) (
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    sys_rst_i,
    // Crystal oscillator, asynchronous
    input  wire logic                    osc_clk_i,
    // Supply level detector outputs, asynchronous
    input  wire logic                    open_level_i,
    input  wire logic                    close_level_i,
    input  wire logic                    commit_level_i,
    input  wire logic                    small_step_i,
    // OTP array read port
    output logic      [1:0]              otp_rd_word_o,
    input  wire logic [7:0]              otp_rd_data_i,
    // OTP array write port
    output logic                         otp_wr_valid_o,
    input  wire logic                    otp_wr_ready_i,
    output sop_pkg::sop_otp_wr_type      otp_wr_o,
    // Reporting
    output logic                         supply_load_o,
    output logic                         meas_out_o,
    output logic      [2:0]              instr_state_o
);

    sop_pkg::sop_core_type       state_reg;
    sop_pkg::sop_core_type       state_next;
    logic [sop_pkg::LVL_W-1:0]   lvl_sync;
    logic [sop_pkg::LVL_W-1:0]   lvl_rise;
    logic                        osc_tick;
    logic                        any_pulse;
    logic                        buf_in_ready;
    logic [sop_pkg::INH_W-1:0]   inh_top;
    logic                        meas_freq;
    logic                        meas_inhb;
    logic                        check_bit;
    logic                        writable;

    // Word that a given instruction state reads or writes.
    function automatic logic [1:0] instr_word(input logic [2:0] instr);
        logic [1:0] w;
        w = sop_pkg::WORD_A;
        if (instr >= sop_pkg::INSTR_WA) begin
            w = 2'(instr - sop_pkg::INSTR_WA);
        end
        return w;
    endfunction : instr_word

    // Tests whether a measured gap lies in one nominal interval window, both bounds included.
    function automatic logic in_window(input logic [sop_pkg::GAP_W-1:0] gap,
                                       input logic [sop_pkg::GAP_W-1:0] lo,
                                       input logic [sop_pkg::GAP_W-1:0] hi);
        return (gap >= lo) && (gap <= hi);
    endfunction : in_window

    sop_sync #(
        .W (sop_pkg::LVL_W)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({small_step_i, commit_level_i, close_level_i, open_level_i, osc_clk_i}),
        .sync_o    (lvl_sync)
    );

    // Rising edges are taken from the second synchroniser stage only.
    assign lvl_rise  = lvl_sync & ~state_reg.lvl_prev;
    assign osc_tick  = lvl_rise[sop_pkg::LVL_OSC];
    assign any_pulse = |lvl_rise[sop_pkg::LVL_STEP:sop_pkg::LVL_OPEN];

    assign inh_top = sop_pkg::INHIB_BASE_OSC
                     + {2'b00, otp_rd_data_i[7:1], 2'b00}
                     - sop_pkg::INH_W'(1);

    assign meas_freq = state_reg.div_cnt[sop_pkg::DIV_W-1];
    assign meas_inhb = (state_reg.inh_cnt < sop_pkg::INHIB_HIGH_OSC);

    // The read data belongs to the word selected on the previous edge.
    assign check_bit = |(state_reg.shreg & otp_rd_data_i);

    assign writable = (state_reg.instr == sop_pkg::INSTR_WA) ||
                      (state_reg.instr == sop_pkg::INSTR_WB);

    always_comb begin
        state_next          = state_reg;
        state_next.lvl_prev = lvl_sync;

        // Free-running divider that also feeds the pad in idle.
        if (osc_tick) begin
            state_next.div_cnt = state_reg.div_cnt + 1'b1;
        end

        // Inhibition-time waveform, one period of base plus n steps.
        if (osc_tick) begin
            if (state_reg.inh_cnt >= inh_top) begin
                state_next.inh_cnt = '0;
            end else begin
                state_next.inh_cnt = state_reg.inh_cnt + 1'b1;
            end
        end

        // Gap counter restarts on each small step and stops at its ceiling.
        if (lvl_rise[sop_pkg::LVL_STEP]) begin
            state_next.gap_cnt = '0;
        end else if (osc_tick && (state_reg.gap_cnt != '1)) begin
            state_next.gap_cnt = state_reg.gap_cnt + 1'b1;
        end

        // Silence counter since the last supply pulse of any kind.
        if (any_pulse) begin
            state_next.idle_cnt = '0;
        end else if (osc_tick && (state_reg.phase != sop_pkg::PH_IDLE)) begin
            state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
        end

        // The buffer takes the pending word as soon as it has room.
        if (state_reg.push_valid && buf_in_ready) begin
            state_next.push_valid = 1'b0;
        end

        if (lvl_rise[sop_pkg::LVL_OPEN]) begin
            state_next.phase   = sop_pkg::PH_REF;
            state_next.instr   = sop_pkg::INSTR_FREQ;
            state_next.shreg   = '0;
            state_next.shifted = 1'b0;
            state_next.armed   = 1'b0;
        end else if (state_reg.phase != sop_pkg::PH_IDLE) begin
            priority case (1'b1)
                (osc_tick && (state_reg.idle_cnt >= IDLE_TIMEOUT_OSC - 1'b1)): begin
                    state_next.phase = sop_pkg::PH_IDLE;
                end
                lvl_rise[sop_pkg::LVL_COMMIT]: begin
                    // A second commit while the first is still pending is dropped.
                    if (state_reg.armed && writable && !state_reg.push_valid) begin
                        state_next.push_valid     = 1'b1;
                        state_next.push_data.word = instr_word(state_reg.instr);
                        state_next.push_data.data = state_reg.shreg;
                    end
                    state_next.phase = sop_pkg::PH_IDLE;
                    state_next.armed = 1'b0;
                end
                lvl_rise[sop_pkg::LVL_CLOSE]: begin
                    // The close and pre-commit levels are the same; only a loaded
                    // word A or word B write state treats the first one as pre-commit.
                    if (writable && state_reg.shifted && !state_reg.armed) begin
                        state_next.armed = 1'b1;
                    end else begin
                        state_next.phase = sop_pkg::PH_IDLE;
                        state_next.armed = 1'b0;
                    end
                end
                lvl_rise[sop_pkg::LVL_STEP]: begin
                    state_next.armed = 1'b0;
                    if (state_reg.phase == sop_pkg::PH_REF) begin
                        state_next.phase = sop_pkg::PH_RUN;
                    end else if (in_window(state_reg.gap_cnt, sop_pkg::STEP_LO,
                                           sop_pkg::STEP_HI)) begin
                        if (state_reg.instr != sop_pkg::INSTR_WD) begin
                            state_next.instr = state_reg.instr + 1'b1;
                        end
                    end else if (in_window(state_reg.gap_cnt, sop_pkg::ZERO_LO,
                                           sop_pkg::ZERO_HI)) begin
                        state_next.shreg   = {1'b0, state_reg.shreg[7:1]};
                        state_next.shifted = 1'b1;
                    end else if (in_window(state_reg.gap_cnt, sop_pkg::ONE_LO,
                                           sop_pkg::ONE_HI)) begin
                        state_next.shreg   = {1'b1, state_reg.shreg[7:1]};
                        state_next.shifted = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (state_next.phase == sop_pkg::PH_IDLE) begin
            state_next.instr = sop_pkg::INSTR_NONE;
        end

        // Word select: state 2 reads word A for its removed-pulse count.
        state_next.rd_word = instr_word(state_reg.instr);

        // Supply load and pad output per instruction state.
        unique case (state_reg.instr)
            sop_pkg::INSTR_FREQ: begin
                state_next.meas = meas_freq;
                state_next.load = meas_freq;
            end
            sop_pkg::INSTR_INHB: begin
                state_next.meas = meas_inhb;
                state_next.load = meas_inhb;
            end
            sop_pkg::INSTR_NONE: begin
                state_next.meas = meas_freq;
                state_next.load = 1'b0;
            end
            default: begin
                state_next.meas = meas_freq;
                state_next.load = check_bit;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg       <= '0;
            state_reg.phase <= sop_pkg::PH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Two-entry buffer keeps committed words while the OTP array is busy.
    sop_buf #(
        .W     ($bits(sop_pkg::sop_otp_wr_type)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (state_reg.push_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (state_reg.push_data),
        .out_valid_o (otp_wr_valid_o),
        .out_ready_i (otp_wr_ready_i),
        .out_data_o  (otp_wr_o)
    );

    assign otp_rd_word_o = state_reg.rd_word;
    assign supply_load_o = state_reg.load;
    assign meas_out_o    = state_reg.meas;
    assign instr_state_o = state_reg.instr;

endmodule : sop_programmer

// >>> design/sop_pkg.sv
package sop_pkg;

    // Oscillator and timing references.
    localparam int OSC_HZ    = 32768;
    localparam int US_PER_S  = 1000000;

    // Nominal gaps between small supply steps, in microseconds.
    localparam int COUNTER_STEP_GAP_US = 700;
    localparam int ZERO_SHIFT_GAP_US   = 1700;
    localparam int ONE_SHIFT_GAP_US    = 2700;
    localparam int GAP_TOL_US          = 300;

    // Window bounds in oscillator cycles: lower bounds round up, upper bounds round down.
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] STEP_LO = GAP_W'(((COUNTER_STEP_GAP_US - GAP_TOL_US) * OSC_HZ
                                              + US_PER_S - 1) / US_PER_S);
    localparam logic [GAP_W-1:0] STEP_HI = GAP_W'(((COUNTER_STEP_GAP_US + GAP_TOL_US) * OSC_HZ)
                                              / US_PER_S);
    localparam logic [GAP_W-1:0] ZERO_LO = GAP_W'(((ZERO_SHIFT_GAP_US - GAP_TOL_US) * OSC_HZ
                                              + US_PER_S - 1) / US_PER_S);
    localparam logic [GAP_W-1:0] ZERO_HI = GAP_W'(((ZERO_SHIFT_GAP_US + GAP_TOL_US) * OSC_HZ)
                                              / US_PER_S);
    localparam logic [GAP_W-1:0] ONE_LO  = GAP_W'(((ONE_SHIFT_GAP_US - GAP_TOL_US) * OSC_HZ
                                              + US_PER_S - 1) / US_PER_S);
    localparam logic [GAP_W-1:0] ONE_HI  = GAP_W'(((ONE_SHIFT_GAP_US + GAP_TOL_US) * OSC_HZ)
                                              / US_PER_S);

    // Silence that ends an instruction state.
    localparam int IDLE_TIMEOUT_S   = 2;
    localparam int IDLE_W           = 17;
    localparam int IDLE_TIMEOUT_OSC = IDLE_TIMEOUT_S * OSC_HZ;

    // Measurement outputs.
    localparam int DIV_W           = 10;
    localparam int INH_W           = 11;
    localparam int INHIB_BASE_US   = 31250;
    localparam int INHIB_STEP_HZ   = 8192;
    localparam logic [INH_W-1:0] INHIB_BASE_OSC = INH_W'(INHIB_BASE_US * OSC_HZ / US_PER_S);
    localparam logic [INH_W-1:0] INHIB_HIGH_OSC = INH_W'(INHIB_BASE_US * OSC_HZ / US_PER_S / 2);
    localparam int INHIB_STEP_SHIFT = $clog2(OSC_HZ / INHIB_STEP_HZ);

    // Instruction counter values.
    localparam logic [2:0] INSTR_NONE = 3'h0;
    localparam logic [2:0] INSTR_FREQ = 3'h1;
    localparam logic [2:0] INSTR_INHB = 3'h2;
    localparam logic [2:0] INSTR_WA   = 3'h3;
    localparam logic [2:0] INSTR_WB   = 3'h4;
    localparam logic [2:0] INSTR_WD   = 3'h6;

    // Word indices.
    localparam logic [1:0] WORD_A = 2'h0;

    // Bit positions of the synchronised oscillator and level-detector inputs.
    localparam int LVL_OSC    = 0;
    localparam int LVL_OPEN   = 1;
    localparam int LVL_CLOSE  = 2;
    localparam int LVL_COMMIT = 3;
    localparam int LVL_STEP   = 4;
    localparam int LVL_W      = 5;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_REF,
        PH_RUN
    } sop_phase_type;

    typedef struct packed {
        logic [1:0] word;
        logic [7:0] data;
    } sop_otp_wr_type;

    typedef struct packed {
        sop_phase_type      phase;
        logic [2:0]         instr;
        logic [7:0]         shreg;
        logic               shifted;
        logic               armed;
        logic [GAP_W-1:0]   gap_cnt;
        logic [IDLE_W-1:0]  idle_cnt;
        logic [DIV_W-1:0]   div_cnt;
        logic [INH_W-1:0]   inh_cnt;
        logic [LVL_W-1:0]   lvl_prev;
        logic [1:0]         rd_word;
        logic               load;
        logic               meas;
        logic               push_valid;
        sop_otp_wr_type     push_data;
    } sop_core_type;

endpackage : sop_pkg

// >>> design/sop_sync.sv
`timescale 1ns/10ps
module sop_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sop_sync_type;

    sop_sync_type state_reg;
    sop_sync_type state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = async_i;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stage2;

endmodule : sop_sync

// >>> design/sop_buf.sv
`timescale 1ns/10ps
module sop_buf #(
    parameter int W     = 10,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wr;
        logic [AW:0]             rd;
    } sop_buf_type;

    sop_buf_type state_reg;
    sop_buf_type state_next;
    logic        full;
    logic        empty;

    // Pointers carry one extra bit so that full and empty stay distinct.
    assign empty       = (state_reg.wr == state_reg.rd);
    assign full        = (state_reg.wr[AW-1:0] == state_reg.rd[AW-1:0]) && !empty;
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = state_reg.mem[state_reg.rd[AW-1:0]];

    always_comb begin
        state_next = state_reg;
        if (in_valid_i && !full) begin
            state_next.mem[state_reg.wr[AW-1:0]] = in_data_i;
            state_next.wr = state_reg.wr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            state_next.rd = state_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : sop_buf

// >>> bench/sop_programmer_properties.sv
`timescale 1ns/10ps
module sop_programmer_properties #(
    parameter logic [sop_pkg::IDLE_W-1:0] IDLE_TIMEOUT_OSC = 17'h10000
) (
    // Clock and reset
    input wire logic                    clk_sys_i,
    input wire logic                    sys_rst_i,
    // Design inputs
    input wire logic                    osc_clk_i,
    input wire logic                    open_level_i,
    input wire logic                    close_level_i,
    input wire logic                    commit_level_i,
    input wire logic                    small_step_i,
    input wire logic [7:0]              otp_rd_data_i,
    input wire logic                    otp_wr_ready_i,
    // Design outputs
    input wire logic [1:0]              otp_rd_word_o,
    input wire logic                    otp_wr_valid_o,
    input wire sop_pkg::sop_otp_wr_type otp_wr_o,
    input wire logic                    supply_load_o,
    input wire logic                    meas_out_o,
    input wire logic [2:0]              instr_state_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // Any detector level restarts the silence count, so the bound errs on the late side.
    logic osc_q;
    int   quiet;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_q <= 1'b0;
            quiet <= 0;
        end else begin
            osc_q <= osc_clk_i;
            if (open_level_i | close_level_i | commit_level_i | small_step_i)
                quiet <= 0;
            else if (osc_clk_i & ~osc_q)
                quiet <= quiet + 1;
        end
    end

    sequence s_open_seen;
        $rose(open_level_i) && !commit_level_i;
    endsequence
    sequence s_meas_settled;
        instr_state_o inside {3'h1, 3'h2} && $stable(instr_state_o) ##1 $stable(instr_state_o);
    endsequence

    a_open_state: assert property (s_open_seen |-> ##[1:5] instr_state_o == 3'h1)
        else $error("open pulse did not select state one");
    a_commit_end: assert property ($rose(commit_level_i) && !open_level_i |->
        ##[1:6] instr_state_o == 3'h0) else $error("commit did not end the state");
    a_count_step: assert property (instr_state_o > 3'h1 && $changed(instr_state_o) |->
        instr_state_o == $past(instr_state_o) + 3'h1) else $error("counter jumped");
    a_instr_range: assert property (instr_state_o <= 3'h6)
        else $error("counter beyond six");
    a_word_sel: assert property (instr_state_o >= 3'h3 && $stable(instr_state_o) |->
        otp_rd_word_o == instr_state_o - 3'h3) else $error("wrong word selected");
    a_load_idle: assert property ((instr_state_o == 3'h0) [*3] |-> !supply_load_o)
        else $error("load on outside a state");
    a_meas_load: assert property (s_meas_settled |-> supply_load_o == meas_out_o)
        else $error("load does not mirror measurement");
    a_wr_hold: assert property (otp_wr_valid_o && !otp_wr_ready_i |=>
        otp_wr_valid_o && $stable(otp_wr_o)) else $error("write word lost in stall");
    a_push_end: assert property ($rose(otp_wr_valid_o) |-> instr_state_o == 3'h0)
        else $error("write without end of state");
    a_idle_end: assert property (quiet > IDLE_TIMEOUT_OSC + 4 |-> instr_state_o == 3'h0)
        else $error("state outlived silence");
endmodule : sop_programmer_properties

bind sop_programmer sop_programmer_properties #(.IDLE_TIMEOUT_OSC(IDLE_TIMEOUT_OSC)) u_props (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .osc_clk_i(osc_clk_i),
    .open_level_i(open_level_i), .close_level_i(close_level_i),
    .commit_level_i(commit_level_i), .small_step_i(small_step_i),
    .otp_rd_data_i(otp_rd_data_i), .otp_wr_ready_i(otp_wr_ready_i),
    .otp_rd_word_o(otp_rd_word_o), .otp_wr_valid_o(otp_wr_valid_o), .otp_wr_o(otp_wr_o),
    .supply_load_o(supply_load_o), .meas_out_o(meas_out_o), .instr_state_o(instr_state_o));

// >>> bench/sop_prog_model.sv
`timescale 1ns/10ps
module sop_prog_model #(
    parameter int HOLDOFF_OSC = 20
) (
    // Bench side
    input  wire logic                    clk_sys_i,
    input  wire logic                    stall_i,
    // Supply detectors and oscillator
    output logic                         osc_clk_o,
    output logic                         open_level_o,
    output logic                         close_level_o,
    output logic                         commit_level_o,
    output logic                         small_step_o,
    // OTP array ports
    input  wire logic [1:0]              otp_rd_word_i,
    output logic      [7:0]              otp_rd_data_o,
    input  wire logic                    otp_wr_valid_i,
    output logic                         otp_wr_ready_o,
    input  wire sop_pkg::sop_otp_wr_type otp_wr_i
);
    // The oscillator runs far faster than a crystal so that runs stay short.
    localparam int STEP_N = sop_pkg::COUNTER_STEP_GAP_US * sop_pkg::OSC_HZ / sop_pkg::US_PER_S;
    localparam int ZERO_N = sop_pkg::ZERO_SHIFT_GAP_US * sop_pkg::OSC_HZ / sop_pkg::US_PER_S;
    localparam int ONE_N  = sop_pkg::ONE_SHIFT_GAP_US * sop_pkg::OSC_HZ / sop_pkg::US_PER_S;
    logic [2:0] lvl = 3'h0;
    logic [7:0] mem [4] = '{default: 8'h00};

    initial osc_clk_o = 1'b0;
    initial small_step_o = 1'b0;
    always #100 osc_clk_o = ~osc_clk_o;
    assign {commit_level_o, close_level_o, open_level_o} = lvl;
    assign otp_rd_data_o  = mem[otp_rd_word_i];
    assign otp_wr_ready_o = ~stall_i;
    always @(posedge clk_sys_i) begin
        if (otp_wr_valid_i && otp_wr_ready_o)
            mem[otp_wr_i.word] <= otp_wr_i.data;
    end

    task automatic pulse(input int b);
        @(posedge clk_sys_i);
        #2 lvl[b] = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #2 lvl[b] = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #2;
    endtask : pulse
    // Holdoff is shortened; the device does not enforce it.
    task automatic open_lvl();
        pulse(0);
        repeat (HOLDOFF_OSC) @(posedge osc_clk_o);
    endtask : open_lvl
    // A step rises mid-period so that each gap is exactly n oscillator rises.
    task automatic step(input int n);
        repeat (n) @(posedge osc_clk_o);
        repeat (4) @(posedge clk_sys_i);
        #2 small_step_o = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #2 small_step_o = 1'b0;
    endtask : step
    task automatic advance();
        step(STEP_N);
    endtask : advance
    task automatic shift(input logic b);
        step(b ? ONE_N : ZERO_N);
    endtask : shift
    task automatic write_word(input logic [2:0] st, input logic [7:0] d);
        open_lvl();
        step(2);
        repeat (st - 1) advance();
        for (int i = 0; i < 8; i++) shift(d[i]);
        repeat (ZERO_N) @(posedge osc_clk_o);
        pulse(1);
        pulse(2);
    endtask : write_word
endmodule : sop_prog_model

// >>> bench/tb_supply_modulated_otp_programmer.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_supply_modulated_otp_programmer;
    localparam logic [sop_pkg::IDLE_W-1:0] IDLE = 17'h00a00;
    logic                    clk_sys_i = 1'b0;
    logic                    sys_rst_i = 1'b1;
    logic                    stall     = 1'b0;
    logic                    osc, op, cl, cm, st, wr_valid, wr_ready, load, meas;
    logic [1:0]              rd_word;
    logic [7:0]              rd_data;
    logic [2:0]              instr;
    sop_pkg::sop_otp_wr_type wr;
    int                      err_total  = 0;
    int                      n_compared = 0;
    int                      cyc        = 0;
    int                      n;

    always #12.5 clk_sys_i = ~clk_sys_i;

    sop_prog_model u_model (.clk_sys_i(clk_sys_i), .stall_i(stall), .osc_clk_o(osc),
        .open_level_o(op), .close_level_o(cl), .commit_level_o(cm), .small_step_o(st),
        .otp_rd_word_i(rd_word), .otp_rd_data_o(rd_data), .otp_wr_valid_i(wr_valid),
        .otp_wr_ready_o(wr_ready), .otp_wr_i(wr));
    sop_programmer #(.IDLE_TIMEOUT_OSC(IDLE)) DUT (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .osc_clk_i(osc), .open_level_i(op), .close_level_i(cl),
        .commit_level_i(cm), .small_step_i(st), .otp_rd_word_o(rd_word),
        .otp_rd_data_i(rd_data), .otp_wr_valid_o(wr_valid), .otp_wr_ready_i(wr_ready),
        .otp_wr_o(wr), .supply_load_o(load), .meas_out_o(meas), .instr_state_o(instr));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            summarize();
        end
    end

    task automatic wait_clk(input int k);
        repeat (k) @(posedge clk_sys_i);
        #2;
    endtask : wait_clk
    // Counts oscillator rises from one rise of the measurement output to the next.
    task automatic meas_period(output int p);
        int   s;
        logic om;
        logic oo;
        s = 0;
        p = 0;
        om = meas;
        oo = osc;
        for (int i = 0; i < 40000 && s < 2; i++) begin
            @(posedge clk_sys_i);
            if (s == 1 && osc && !oo)
                p++;
            if (meas && !om)
                s++;
            om = meas;
            oo = osc;
        end
    endtask : meas_period

    task automatic t_freq();
        u_model.open_lvl();
        `CHK("instr after open", 3'h1, instr)
        meas_period(n);
        `CHK("freq period", 1024, n)
        u_model.pulse(1);
        `CHK("instr after close", 3'h0, instr)
    endtask : t_freq

    task automatic t_decode();
        u_model.open_lvl();
        u_model.step(2);
        wait_clk(4);
        `CHK("instr after reference", 3'h1, instr)
        u_model.advance();
        wait_clk(4);
        `CHK("instr advanced", 3'h2, instr)
        u_model.step(40);
        wait_clk(4);
        `CHK("instr odd gap", 3'h2, instr)
        for (int k = 3; k <= 7; k++) begin
            u_model.advance();
            wait_clk(4);
            `CHK("instr step", (k > 6) ? 3'h6 : 3'(k), instr)
        end
        u_model.pulse(1);
        `CHK("instr closed", 3'h0, instr)
    endtask : t_decode

    // Two commits while the array stalls fill the buffer; both words drain in order.
    task automatic t_write();
        stall = 1'b1;
        u_model.write_word(3'h4, 8'h35);
        wait_clk(4);
        `CHK("wr valid", 1'b1, wr_valid)
        `CHK("wr word B", {2'h1, 8'h35}, wr)
        `CHK("instr after commit", 3'h0, instr)
        u_model.write_word(3'h3, 8'h0b);
        wait_clk(4);
        `CHK("wr head kept", {2'h1, 8'h35}, wr)
        stall = 1'b0;
        wait_clk(4);
        `CHK("wr drained", 1'b0, wr_valid)
        `CHK("word B stored", 8'h35, u_model.mem[1])
        `CHK("word A stored", 8'h0b, u_model.mem[0])
    endtask : t_write

    task automatic t_read();
        u_model.open_lvl();
        u_model.step(2);
        repeat (3) u_model.advance();
        for (int k = 0; k < 8; k++) begin
            u_model.shift(k == 0);
            wait_clk(4);
            `CHK("load bit", 1'(8'h35 >> (7 - k)), load)
        end
        u_model.pulse(1);
    endtask : t_read

    task automatic t_inhib();
        u_model.open_lvl();
        u_model.step(2);
        u_model.advance();
        wait_clk(4);
        `CHK("instr inhib", 3'h2, instr)
        meas_period(n);
        `CHK("inhib period", 1024 + 4 * (8'h0b >> 1), n)
        u_model.pulse(1);
    endtask : t_inhib

    task automatic t_timeout();
        u_model.open_lvl();
        u_model.step(2);
        repeat (IDLE - 20) @(posedge osc);
        wait_clk(1);
        `CHK("instr before silence", 3'h1, instr)
        repeat (30) @(posedge osc);
        wait_clk(4);
        `CHK("instr after silence", 3'h0, instr)
    endtask : t_timeout

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #2 sys_rst_i = 1'b0;
        repeat (8) @(posedge osc);
        `CHK("reset instr", 3'h0, instr)
        `CHK("reset valid", 1'b0, wr_valid)
        t_freq();
        t_decode();
        t_write();
        t_read();
        t_inhib();
        t_timeout();
        summarize();
    end
endmodule : tb_supply_modulated_otp_programmer
